// ---- common/srd_params.svh ----
// Register indices, field positions, reset values and domain codes of the rate bank.
// Assumes inclusion by srd_pkg.sv and by the testbench that checks the registers.
`ifndef SRD_PARAMS_SVH
`define SRD_PARAMS_SVH

// Register indices; the byte address of a register is four times its index.
`define SRD_IDX_IN1L 12'h313
`define SRD_IDX_IN1R 12'h317
`define SRD_IDX_IN2L 12'h31B
`define SRD_IDX_IN2R 12'h31F
`define SRD_IDX_IN3L 12'h323
`define SRD_IDX_IN3R 12'h327
`define SRD_IDX_IN4L 12'h32B
`define SRD_IDX_IN4R 12'h32F
`define SRD_IDX_IN_COMMON 12'h308
`define SRD_IDX_IN_MODE 12'h309
`define SRD_IDX_STATUS 12'h30A
`define SRD_IDX_OUT 12'h408
`define SRD_IDX_PORT1 12'h503
`define SRD_IDX_PORT2 12'h543
`define SRD_IDX_PORT3 12'h583
`define SRD_IDX_SPDIF 12'h5C2

// Bus geometry.
`define SRD_ADDR_W 16
`define SRD_IDX_W 12
`define SRD_IDX_MSB 13
`define SRD_IDX_LSB 2
`define SRD_REG_W 16
`define SRD_REG_BYTES 2

// Field positions.
`define SRD_RATE_W 5
`define SRD_RATE_MSB 15
`define SRD_RATE_LSB 11
`define SRD_SPDIF_MSB 8
`define SRD_SPDIF_LSB 4
`define SRD_MODE_BIT 0
`define SRD_FAULT_BIT 0

// Reset values and mode encoding.
`define SRD_RATE_RST 5'h00
`define SRD_MODE_RST 1'b0
`define SRD_MODE_PER_CHANNEL 1'b1

// Domain codes.
`define SRD_CODE_SYNC1 5'h00
`define SRD_CODE_SYNC2 5'h01
`define SRD_CODE_SYNC3 5'h02
`define SRD_CODE_ASYNC_A 5'h08
`define SRD_CODE_ASYNC_B 5'h09

// Bus answers.
`define SRD_RESP_OKAY 2'h0
`define SRD_RESP_SLVERR 2'h2
`define SRD_READ_ZERO 32'h0000_0000

`endif

// ---- common/srd_pkg.sv ----
// Types shared by the rate bank and its AXI4-Lite slave.
// Assumes srd_params.svh is on the include path.
package srd_pkg;
  `include "srd_params.svh"

  typedef logic [`SRD_RATE_W-1:0] srd_rate_t;
  typedef logic [`SRD_REG_W-1:0] srd_reg_t;
  typedef logic [`SRD_IDX_W-1:0] srd_idx_t;
  typedef logic [`SRD_ADDR_W-1:0] srd_addr_t;

  // Master-driven AXI4-Lite signals.
  typedef struct packed {
    srd_addr_t awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    srd_addr_t araddr;
    logic arvalid;
    logic rready;
  } srd_axil_req_t;

  // Slave-driven AXI4-Lite signals.
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } srd_axil_rsp_t;

  // Register access offered by the slave to the bank.
  typedef struct packed {
    logic wr_en;
    srd_addr_t wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic rd_en;
    srd_addr_t rd_addr;
  } srd_acc_t;

  // Bank answer to an access, valid in the cycle of the access.
  typedef struct packed {
    logic wr_err;
    logic [31:0] rd_data;
    logic rd_err;
  } srd_ans_t;

  // Slave state.
  typedef struct packed {
    logic aw_held;
    srd_addr_t awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } srd_slv_t;

  // Bank state.
  typedef struct packed {
    srd_rate_t [7:0] in_rate;
    srd_rate_t common_in_rate;
    logic in_mode;
    srd_rate_t out_rate;
    srd_rate_t [2:0] port_rate;
    srd_rate_t spdif_rate;
    logic fault;
    srd_rate_t [7:0] in_eff;
  } srd_bank_t;
endpackage

// ---- design/srd_axil_slave.sv ----
// AXI4-Lite slave front end of the rate bank: one write and one read under way.
// Assumes the bank answers each access combinationally in the cycle it is offered.
`timescale 1ns/10ps
module srd_axil_slave (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Bus side.
  input wire srd_pkg::srd_axil_req_t axi_req_in,
  output srd_pkg::srd_axil_rsp_t axi_rsp_out,
  // Bank side.
  output srd_pkg::srd_acc_t acc_out,
  input wire srd_pkg::srd_ans_t ans_in
);
  import srd_pkg::*;

  srd_slv_t q;
  srd_slv_t next_q;
  logic aw_hs;
  logic w_hs;
  logic wr_fire;
  logic ar_hs;

  // Ready stays low while a response waits, which keeps one write and one read in flight.
  always_comb begin
    axi_rsp_out.awready = !q.aw_held && !q.bvalid;
    axi_rsp_out.wready = !q.w_held && !q.bvalid;
    axi_rsp_out.bresp = q.bresp;
    axi_rsp_out.bvalid = q.bvalid;
    axi_rsp_out.arready = !q.rvalid;
    axi_rsp_out.rdata = q.rdata;
    axi_rsp_out.rresp = q.rresp;
    axi_rsp_out.rvalid = q.rvalid;
    aw_hs = axi_req_in.awvalid && axi_rsp_out.awready;
    w_hs = axi_req_in.wvalid && axi_rsp_out.wready;
    ar_hs = axi_req_in.arvalid && axi_rsp_out.arready;
    wr_fire = (q.aw_held || aw_hs) && (q.w_held || w_hs) && !q.bvalid;
    acc_out.wr_en = wr_fire;
    acc_out.wr_addr = q.aw_held ? q.awaddr : axi_req_in.awaddr;
    acc_out.wr_data = q.w_held ? q.wdata : axi_req_in.wdata;
    acc_out.wr_strb = q.w_held ? q.wstrb : axi_req_in.wstrb;
    acc_out.rd_en = ar_hs;
    acc_out.rd_addr = axi_req_in.araddr;
  end

  // Address and data may arrive in either order; the first is parked until the second.
  always_comb begin
    next_q = q;
    if (aw_hs && !wr_fire) begin
      next_q.aw_held = 1'b1;
      next_q.awaddr = axi_req_in.awaddr;
    end
    if (w_hs && !wr_fire) begin
      next_q.w_held = 1'b1;
      next_q.wdata = axi_req_in.wdata;
      next_q.wstrb = axi_req_in.wstrb;
    end
    if (q.bvalid && axi_req_in.bready) begin
      next_q.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = ans_in.wr_err ? `SRD_RESP_SLVERR : `SRD_RESP_OKAY;
    end
    if (q.rvalid && axi_req_in.rready) begin
      next_q.rvalid = 1'b0;
    end
    if (ar_hs) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = ans_in.rd_data;
      next_q.rresp = ans_in.rd_err ? `SRD_RESP_SLVERR : `SRD_RESP_OKAY;
    end
  end

  // State register.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

// ---- design/srd_rate_bank.sv ----
// Sample-rate domain select bank: assigns input paths, the output path, three serial
// ports and the S/PDIF transmitter to rate domains, written over AXI4-Lite.
// Assumes software keeps the mixer-clearing and rate-range duties listed below.
//
// How it works
// R1 - A per-channel input rate field drives its path only while the input mode bit is 1.
// R2 - Each per-channel input field is bits 15:11, resets to 0x00, takes only codes 0x00-0x02.
// R3 - Software picks an input domain only if it runs between 8 and 192 kHz.
// R4 - With microphone oversampling 01X software caps the channel at 48 or 96 kHz.
// R5 - The output path field at bits 15:11 takes codes 0x00-0x02, 0x08 and 0x09 only.
// R6 - Each of the three serial ports has a field at bits 15:11 with the same five codes.
// R7 - Software puts the output path and serial ports only on domains of 8 to 384 kHz.
// R8 - Software zeroes every output mixer source before changing the output path rate.
// R9 - Software zeroes a serial port's transmit mixer sources before changing its rate.
// R10 - The S/PDIF transmitter field sits at bits 8:4, resets to 0x00, with the same five codes.
// R11 - Software puts the S/PDIF transmitter only on domains of 32 to 192 kHz.
// R12 - Software zeroes every S/PDIF source before changing the S/PDIF rate.
// R13 - With the input mode bit at 0 all input paths follow the common input rate field.
// R14 - Every field reads back what was last written and a write leaves other fields alone; the fault flag is write-1-to-clear and set by any SLVERR write.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module srd_rate_bank (
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // Register bus.
  input wire srd_pkg::srd_axil_req_t AXI_REQ_IN,
  output srd_pkg::srd_axil_rsp_t AXI_RSP_OUT,
  // Selected domains.
  output srd_pkg::srd_rate_t [7:0] IN_PATH_RATE_OUT,
  output srd_pkg::srd_rate_t OUT_PATH_RATE_OUT,
  output srd_pkg::srd_rate_t [2:0] SERIAL_PORT_RATE_OUT,
  output srd_pkg::srd_rate_t SPDIF_TX_RATE_OUT,
  output logic IN_RATE_MODE_OUT
);
  import srd_pkg::*;

  // Input channel order: 1L, 1R, 2L, 2R, 3L, 3R, 4L, 4R.
  localparam srd_idx_t IN_IDX [8] = '{`SRD_IDX_IN1L, `SRD_IDX_IN1R, `SRD_IDX_IN2L,
    `SRD_IDX_IN2R, `SRD_IDX_IN3L, `SRD_IDX_IN3R, `SRD_IDX_IN4L, `SRD_IDX_IN4R};
  localparam srd_idx_t PORT_IDX [3] = '{`SRD_IDX_PORT1, `SRD_IDX_PORT2, `SRD_IDX_PORT3};

  srd_bank_t q;
  srd_bank_t next_q;
  srd_acc_t acc;
  srd_ans_t ans;
  srd_idx_t wr_idx;
  srd_idx_t rd_idx;
  logic wr_hit;
  logic rd_hit;
  srd_reg_t wr_old;
  srd_reg_t wr_new;
  srd_reg_t rd_img;
  srd_rate_t wr_code;
  srd_rate_t wr_spdif_code;
  logic wr_in_target;
  logic wr_bad_code;

  // Input paths accept only the synchronous domains.
  function automatic logic in_code_ok(srd_rate_t code);
    return (code == `SRD_CODE_SYNC1) || (code == `SRD_CODE_SYNC2) ||
      (code == `SRD_CODE_SYNC3);
  endfunction

  // Output, serial port and S/PDIF paths also accept the two asynchronous domains.
  function automatic logic out_code_ok(srd_rate_t code);
    return in_code_ok(code) || (code == `SRD_CODE_ASYNC_A) || (code == `SRD_CODE_ASYNC_B);
  endfunction

  // A register is mapped only at an aligned byte address with no bits above the index.
  function automatic logic addr_ok(srd_addr_t addr);
    return (addr[`SRD_IDX_LSB-1:0] == '0) && (addr[`SRD_ADDR_W-1:`SRD_IDX_MSB+1] == '0);
  endfunction

  function automatic srd_idx_t addr_idx(srd_addr_t addr);
    return addr[`SRD_IDX_MSB:`SRD_IDX_LSB];
  endfunction

  // Byte lanes without a strobe keep the old bits, so one write never disturbs another
  // field of the same register.
  function automatic srd_reg_t merge_lanes(srd_reg_t old, logic [31:0] data, logic [3:0] strb);
    srd_reg_t res;
    res = old;
    for (int b = 0; b < `SRD_REG_BYTES; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Read image of one register; the top bit says whether the index is mapped.
  function automatic logic [`SRD_REG_W:0] reg_image(srd_bank_t s, srd_idx_t idx);
    srd_reg_t img;
    logic hit;
    img = '0;
    hit = 1'b1;
    if (idx == `SRD_IDX_IN_COMMON) begin
      img[`SRD_RATE_MSB:`SRD_RATE_LSB] = s.common_in_rate;
    end else if (idx == `SRD_IDX_IN_MODE) begin
      img[`SRD_MODE_BIT] = s.in_mode;
    end else if (idx == `SRD_IDX_STATUS) begin
      img[`SRD_FAULT_BIT] = s.fault;
    end else if (idx == `SRD_IDX_OUT) begin
      img[`SRD_RATE_MSB:`SRD_RATE_LSB] = s.out_rate;
    end else if (idx == `SRD_IDX_SPDIF) begin
      img[`SRD_SPDIF_MSB:`SRD_SPDIF_LSB] = s.spdif_rate;
    end else begin
      hit = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (idx == IN_IDX[i]) begin
          hit = 1'b1;
          img[`SRD_RATE_MSB:`SRD_RATE_LSB] = s.in_rate[i];
        end
      end
      for (int p = 0; p < 3; p++) begin
        if (idx == PORT_IDX[p]) begin
          hit = 1'b1;
          img[`SRD_RATE_MSB:`SRD_RATE_LSB] = s.port_rate[p];
        end
      end
    end
    return {hit, img};
  endfunction

  // Bus handshakes live in the slave; the bank answers in the same cycle.
  srd_axil_slave u_slave (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .axi_req_in(AXI_REQ_IN),
    .axi_rsp_out(AXI_RSP_OUT),
    .acc_out(acc),
    .ans_in(ans)
  );

  // Decode of the write and read targets.
  always_comb begin
    wr_idx = addr_idx(acc.wr_addr);
    rd_idx = addr_idx(acc.rd_addr);
    {wr_hit, wr_old} = reg_image(q, wr_idx);
    wr_hit = wr_hit && addr_ok(acc.wr_addr);
    {rd_hit, rd_img} = reg_image(q, rd_idx);
    rd_hit = rd_hit && addr_ok(acc.rd_addr);
    wr_new = merge_lanes(wr_old, acc.wr_data, acc.wr_strb);
    wr_code = wr_new[`SRD_RATE_MSB:`SRD_RATE_LSB];
    wr_spdif_code = wr_new[`SRD_SPDIF_MSB:`SRD_SPDIF_LSB];
    wr_in_target = (wr_idx == `SRD_IDX_IN_COMMON);
    for (int i = 0; i < 8; i++) begin
      if (wr_idx == IN_IDX[i]) begin
        wr_in_target = 1'b1;
      end
    end
  end

  // Register writes. A write carrying a reserved code is refused as a whole: the field
  // keeps its old value, the bus sees SLVERR and the fault flag is raised, because a
  // reserved domain would leave the path without a clock.
  always_comb begin
    next_q = q;
    wr_bad_code = 1'b0;
    if (acc.wr_en && wr_hit) begin
      if (wr_idx == `SRD_IDX_IN_MODE) begin
        next_q.in_mode = wr_new[`SRD_MODE_BIT];
      end else if (wr_idx == `SRD_IDX_STATUS) begin
        if (acc.wr_strb[0] && acc.wr_data[`SRD_FAULT_BIT]) begin
          next_q.fault = 1'b0;
        end
      end else if (wr_idx == `SRD_IDX_SPDIF) begin
        if (out_code_ok(wr_spdif_code)) begin
          next_q.spdif_rate = wr_spdif_code; // [R10] [R14]
        end else begin
          wr_bad_code = 1'b1;
        end
      end else if (wr_in_target) begin
        if (!in_code_ok(wr_code)) begin
          wr_bad_code = 1'b1; // [R2]
        end else if (wr_idx == `SRD_IDX_IN_COMMON) begin
          next_q.common_in_rate = wr_code;
        end else begin
          for (int i = 0; i < 8; i++) begin
            if (wr_idx == IN_IDX[i]) begin
              next_q.in_rate[i] = wr_code; // [R2] [R14]
            end
          end
        end
      end else if (!out_code_ok(wr_code)) begin
        wr_bad_code = 1'b1; // [R5] [R6]
      end else if (wr_idx == `SRD_IDX_OUT) begin
        next_q.out_rate = wr_code; // [R5] [R14]
      end else begin
        for (int p = 0; p < 3; p++) begin
          if (wr_idx == PORT_IDX[p]) begin
            next_q.port_rate[p] = wr_code; // [R6] [R14]
          end
        end
      end
    end
    // A new fault in the cycle of its clear wins over the clear.
    if (acc.wr_en && (wr_bad_code || !wr_hit)) begin
      next_q.fault = 1'b1;
    end
    // Each input path follows its own field or the common one, as the mode bit says.
    for (int i = 0; i < 8; i++) begin
      if (next_q.in_mode == `SRD_MODE_PER_CHANNEL) begin
        next_q.in_eff[i] = next_q.in_rate[i]; // [R1]
      end else begin
        next_q.in_eff[i] = next_q.common_in_rate; // [R13]
      end
    end
  end

  // Answers to the slave: unmapped addresses give SLVERR and read as zero.
  always_comb begin
    ans.wr_err = !wr_hit || wr_bad_code;
    ans.rd_err = !rd_hit;
    ans.rd_data = rd_hit ? {16'h0000, rd_img} : `SRD_READ_ZERO; // [R14]
  end

  // State register; every rate field resets to the first synchronous domain, the mode bit and the fault flag to 0.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Outputs all come straight from the state register.
  assign IN_PATH_RATE_OUT = q.in_eff;
  assign OUT_PATH_RATE_OUT = q.out_rate;
  assign SERIAL_PORT_RATE_OUT = q.port_rate;
  assign SPDIF_TX_RATE_OUT = q.spdif_rate;
  assign IN_RATE_MODE_OUT = q.in_mode;

  // Checks on the selected domains.
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  per_channel_use_a: assert property ( // [R1]
    (q.in_mode == `SRD_MODE_PER_CHANNEL) |-> (IN_PATH_RATE_OUT == q.in_rate))
    else $error("Per-channel input rate not driving its path.");

  common_rate_use_a: assert property ( // [R13]
    (q.in_mode != `SRD_MODE_PER_CHANNEL) |-> (IN_PATH_RATE_OUT == {8{q.common_in_rate}}))
    else $error("Input paths not following the common rate.");

  input_reserved_refused_a: assert property ( // [R2]
    (acc.wr_en && wr_hit && wr_in_target && !in_code_ok(wr_code))
      |=> ($stable(q.in_rate) && $stable(q.common_in_rate) && q.fault))
    else $error("Reserved input rate code was accepted.");

  output_code_legal_a: assert property ( // [R5]
    out_code_ok(OUT_PATH_RATE_OUT))
    else $error("Output path holds a reserved rate code.");

  port_code_legal_a: assert property ( // [R6]
    out_code_ok(SERIAL_PORT_RATE_OUT[0]) && out_code_ok(SERIAL_PORT_RATE_OUT[1]) &&
      out_code_ok(SERIAL_PORT_RATE_OUT[2]))
    else $error("Serial port holds a reserved rate code.");

  spdif_write_a: assert property ( // [R10]
    (acc.wr_en && wr_idx == `SRD_IDX_SPDIF && addr_ok(acc.wr_addr) && (&acc.wr_strb[1:0]))
      |=> (SPDIF_TX_RATE_OUT == (out_code_ok($past(wr_spdif_code)) ?
        $past(wr_spdif_code) : $past(SPDIF_TX_RATE_OUT))))
    else $error("S/PDIF rate write not taken as expected.");

  // The expected value is taken from the bus data, not from the merged image, so a slip in
  // the lane merge or the field slice shows up here.
  output_readback_a: assert property ( // [R14]
    (acc.wr_en && wr_hit && wr_idx == `SRD_IDX_OUT && acc.wr_strb[1] &&
      out_code_ok(acc.wr_data[`SRD_RATE_MSB:`SRD_RATE_LSB]))
      |=> (OUT_PATH_RATE_OUT == $past(acc.wr_data[`SRD_RATE_MSB:`SRD_RATE_LSB])))
    else $error("Output rate does not hold the value last written.");

  // A read of the output register must hand back the field that the path is using.
  output_read_path_a: assert property ( // [R14]
    (acc.rd_en && rd_idx == `SRD_IDX_OUT && addr_ok(acc.rd_addr))
      |=> (AXI_RSP_OUT.rdata[`SRD_RATE_MSB:`SRD_RATE_LSB] == $past(OUT_PATH_RATE_OUT)))
    else $error("Output rate read does not match the selected domain.");

  other_fields_kept_a: assert property ( // [R14]
    (acc.wr_en && wr_idx != `SRD_IDX_OUT) |=> $stable(OUT_PATH_RATE_OUT))
    else $error("Write to another register disturbed the output rate.");
endmodule

// ---- sim/srd_rate_bank_tb.sv ----
// Self-checking bench for the rate bank: register rows, input mode, lane strobes and resets.
// Assumes the package, the header and the design files are compiled before this file.
`timescale 1ns/10ps
`include "srd_params.svh"
module srd_rate_bank_tb;
  import srd_pkg::*;

  // One row: register index, written half-word, expected readback, refusal expected.
  typedef struct packed {
    srd_idx_t idx;
    srd_reg_t wd;
    srd_reg_t rd;
    logic err;
  } srd_row_t;

  logic sys_clk;
  logic rst_n;
  srd_axil_req_t axi_req;
  srd_axil_rsp_t axi_rsp;
  srd_rate_t [7:0] in_rate;
  srd_rate_t out_rate;
  srd_rate_t [2:0] port_rate;
  srd_rate_t spdif_rate;
  logic in_mode;
  int fails;
  int comparisons;
  logic [31:0] rdata;
  logic [1:0] rresp;

  // Each reserved code follows a legal row for the same register, so a refused write must leave the last value.
  // Every legal code stands for a domain that software may give that path; the mixer and
  // S/PDIF sources live outside this block and are taken as cleared before each change.
  localparam srd_row_t rows [22] = '{
    '{12'h313, 16'h17FF, 16'h1000, 1'b0}, '{12'h317, 16'h0800, 16'h0800, 1'b0},
    '{12'h31B, 16'h0800, 16'h0800, 1'b0}, '{12'h31F, 16'h1000, 16'h1000, 1'b0},
    '{12'h323, 16'h1000, 16'h1000, 1'b0}, '{12'h327, 16'h0800, 16'h0800, 1'b0},
    '{12'h32B, 16'h0800, 16'h0800, 1'b0}, '{12'h32F, 16'h1000, 16'h1000, 1'b0},
    '{12'h313, 16'h1800, 16'h1000, 1'b1}, '{12'h32F, 16'h4000, 16'h1000, 1'b1},
    '{12'h408, 16'h4000, 16'h4000, 1'b0}, '{12'h408, 16'h4800, 16'h4800, 1'b0},
    '{12'h408, 16'h5000, 16'h4800, 1'b1}, '{12'h408, 16'h0000, 16'h0000, 1'b0},
    '{12'h408, 16'h1000, 16'h1000, 1'b0}, '{12'h503, 16'h4000, 16'h4000, 1'b0},
    '{12'h543, 16'h4800, 16'h4800, 1'b0}, '{12'h583, 16'h0800, 16'h0800, 1'b0},
    '{12'h503, 16'hF800, 16'h4000, 1'b1}, '{12'h5C2, 16'h0090, 16'h0090, 1'b0},
    '{12'h5C2, 16'hF08F, 16'h0080, 1'b0}, '{12'h5C2, 16'h0030, 16'h0080, 1'b1}
  };

  srd_rate_bank i_srd_rate_bank (
    .SYS_CLK_IN(sys_clk),
    .RST_N_IN(rst_n),
    .AXI_REQ_IN(axi_req),
    .AXI_RSP_OUT(axi_rsp),
    .IN_PATH_RATE_OUT(in_rate),
    .OUT_PATH_RATE_OUT(out_rate),
    .SERIAL_PORT_RATE_OUT(port_rate),
    .SPDIF_TX_RATE_OUT(spdif_rate),
    .IN_RATE_MODE_OUT(in_mode)
  );

  // Free-running 10 MHz clock.
  always begin
    #50;
    sys_clk = ~sys_clk;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Write cycle; ready is looked at on the falling edge so the rising edge never races it.
  task automatic wr(input srd_idx_t idx, input srd_reg_t data, input logic [3:0] strb,
                    input logic [1:0] eresp);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    logic done;
    logic [1:0] resp;
    @(posedge sys_clk);
    axi_req.awaddr <= {2'h0, idx, 2'h0};
    axi_req.awvalid <= 1'b1;
    axi_req.wdata <= {16'h0000, data};
    axi_req.wstrb <= strb;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge sys_clk);
      aw_hs = axi_req.awvalid && axi_rsp.awready;
      w_hs = axi_req.wvalid && axi_rsp.wready;
      b_hs = axi_rsp.bvalid;
      resp = axi_rsp.bresp;
      @(posedge sys_clk);
      if (aw_hs) axi_req.awvalid <= 1'b0;
      if (w_hs) axi_req.wvalid <= 1'b0;
      if (b_hs) begin
        axi_req.bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk("write response", resp, eresp);
  endtask

  // Read cycle with the same sampling scheme as the write cycle.
  task automatic rd(input srd_idx_t idx, output logic [31:0] data, output logic [1:0] resp);
    logic ar_hs;
    logic done;
    @(posedge sys_clk);
    axi_req.araddr <= {2'h0, idx, 2'h0};
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge sys_clk);
      ar_hs = axi_req.arvalid && axi_rsp.arready;
      done = axi_rsp.rvalid;
      data = axi_rsp.rdata;
      resp = axi_rsp.rresp;
      @(posedge sys_clk);
      if (ar_hs) axi_req.arvalid <= 1'b0;
      if (done) axi_req.rready <= 1'b0;
    end
  endtask

  // Reads a register and compares data and response.
  task automatic rdchk(input srd_idx_t idx, input logic [31:0] exp, input logic [1:0] eresp);
    rd(idx, rdata, rresp);
    chk("read data", rdata, exp);
    chk("read response", rresp, eresp);
  endtask

  // Reset state of every output and of three registers.
  task automatic zero_chk();
    @(negedge sys_clk);
    chk("input paths", in_rate, 40'h0);
    chk("other outputs", {out_rate, port_rate, spdif_rate, in_mode}, 40'h0);
    rdchk(12'h313, 32'h0, `SRD_RESP_OKAY);
    rdchk(12'h408, 32'h0, `SRD_RESP_OKAY);
    rdchk(12'h5C2, 32'h0, `SRD_RESP_OKAY);
  endtask

  // Domain output that belongs to a register index.
  function automatic srd_rate_t rate_of(input srd_idx_t idx);
    srd_idx_t k;
    k = (idx - `SRD_IDX_IN1L) >> 2;
    case (idx)
      `SRD_IDX_OUT: rate_of = out_rate;
      `SRD_IDX_PORT1: rate_of = port_rate[0];
      `SRD_IDX_PORT2: rate_of = port_rate[1];
      `SRD_IDX_PORT3: rate_of = port_rate[2];
      `SRD_IDX_SPDIF: rate_of = spdif_rate;
      default: rate_of = in_rate[k[2:0]];
    endcase
  endfunction

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    end_sim();
  end

  // Main sequence.
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    axi_req = '0;
    fails = 0;
    comparisons = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    zero_chk();
    // Unmapped index, fault flag and both input modes, then the row table under per-channel mode: written codes, refusals and readback.
    rdchk(12'h400, 32'h0, `SRD_RESP_SLVERR);
    wr(12'h400, 16'h1000, 4'h3, `SRD_RESP_SLVERR);
    rdchk(12'h30A, 32'h1, `SRD_RESP_OKAY);
    wr(12'h30A, 16'h0001, 4'h3, `SRD_RESP_OKAY);
    rdchk(12'h30A, 32'h0, `SRD_RESP_OKAY);
    wr(12'h308, 16'h0800, 4'h3, `SRD_RESP_OKAY);
    wr(12'h313, 16'h1000, 4'h3, `SRD_RESP_OKAY);
    @(negedge sys_clk);
    chk("input paths", in_rate, {8{5'h01}});
    wr(12'h309, 16'h0001, 4'h3, `SRD_RESP_OKAY);
    @(negedge sys_clk);
    chk("input paths", in_rate, {{7{5'h00}}, 5'h02});
    chk("input mode", in_mode, 40'h1);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd, 4'h3,
         rows[i].err ? `SRD_RESP_SLVERR : `SRD_RESP_OKAY);
      rdchk(rows[i].idx, {16'h0000, rows[i].rd}, `SRD_RESP_OKAY);
      chk("rate output", rate_of(rows[i].idx),
          (rows[i].idx == 12'h5C2) ? rows[i].rd[8:4] : rows[i].rd[15:11]);
    end
    // Back to the common field: per-channel values must no longer show.
    wr(12'h309, 16'h0000, 4'h3, `SRD_RESP_OKAY);
    @(negedge sys_clk);
    chk("input paths", in_rate, {8{5'h01}});
    // A low-lane write must leave the rate field in the upper lane alone.
    wr(12'h408, 16'h4800, 4'h1, `SRD_RESP_OKAY);
    rdchk(12'h408, 32'h1000, `SRD_RESP_OKAY);
    wr(12'h408, 16'h4800, 4'h2, `SRD_RESP_OKAY);
    rdchk(12'h408, 32'h4800, `SRD_RESP_OKAY);
    chk("output path", out_rate, 40'h09);
    // Second reset in mid-run clears everything again.
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    zero_chk();
    end_sim();
  end
endmodule
